/* prot_pkg.sv */
// Purpose: Shared constants and carriers for the battery protection monitor
// Assumes: Thresholds in mV, mA and 0.1 degC units; current signed
// Notes:   Offsets are register byte addresses on the APB slave
package prot_pkg;

   // Register byte addresses
   localparam logic [11:0] A_CTRL       = 12'h000;
   localparam logic [11:0] A_CHG_V      = 12'h004;
   localparam logic [11:0] A_OV_MARGIN  = 12'h008;
   localparam logic [11:0] A_CELL_HI    = 12'h00C;
   localparam logic [11:0] A_CELL_HI_RS = 12'h010;
   localparam logic [11:0] A_CELL_LO    = 12'h014;
   localparam logic [11:0] A_CELL_LO_RS = 12'h018;
   localparam logic [11:0] A_OVLD_I     = 12'h01C;
   localparam logic [11:0] A_FCLR_I     = 12'h020;
   localparam logic [11:0] A_DOC_I      = 12'h024;
   localparam logic [11:0] A_DOC_T      = 12'h028;
   localparam logic [11:0] A_COC_I      = 12'h02C;
   localparam logic [11:0] A_COC_T      = 12'h030;
   localparam logic [11:0] A_SAFE_V     = 12'h034;
   localparam logic [11:0] A_SOT_C      = 12'h038;
   localparam logic [11:0] A_SOT_D      = 12'h03C;
   localparam logic [11:0] A_SOT_T      = 12'h040;
   localparam logic [11:0] A_HOT_C      = 12'h044;
   localparam logic [11:0] A_HOT_C_RS   = 12'h048;
   localparam logic [11:0] A_HOT_D      = 12'h04C;
   localparam logic [11:0] A_HOT_D_RS   = 12'h050;
   localparam logic [11:0] A_COLD_C     = 12'h054;
   localparam logic [11:0] A_STATUS     = 12'h058;
   localparam logic [11:0] A_MEAS_V     = 12'h05C;
   localparam logic [11:0] A_MEAS_I     = 12'h060;
   localparam logic [11:0] A_MEAS_T     = 12'h064;
   localparam logic [11:0] A_CELL_MAX   = 12'h068;
   localparam logic [11:0] A_CELL_MIN   = 12'h06C;

   // Control register fields
   localparam int C_VALIDATE  = 0;
   localparam int C_TDIS      = 1;
   localparam int C_PF_SOV    = 2;
   localparam int C_PF_SAFETY_HOT_CHARGE_LIMIT   = 3;
   localparam int C_PF_SAFETY_HOT_DISCHARGE_LIMIT   = 4;
   localparam int C_PF_CLEAR  = 5;

   // Small-current re-enable levels, mA
   localparam logic [15:0] DSG_ON_MA  = 16'h0096;
   localparam logic [15:0] CHG_ON_MA  = 16'h0032;
   // Cold charge suspend ceiling, 0.1 degC
   localparam logic [15:0] COLD_MAX   = 16'h007F;
   localparam logic [15:0] Z16        = 16'h0000;
   localparam logic [7:0]  Z8         = 8'h00;
   // Reset values: limits parked at the ends of their range; CNT_MAX caps the counters
   localparam logic [15:0] U16_MAX    = 16'hFFFF;
   localparam logic [15:0] S16_MAX    = 16'h7FFF;
   localparam logic [15:0] S16_MIN    = 16'h8000;
   localparam logic [7:0]  CNT_MAX    = 8'hFF;
   localparam logic [5:0]  CTRL_RST   = 6'h01;

   typedef struct packed {
      logic [15:0] pack_mv;
      logic [15:0] avg_ma;    // signed, positive charges
      logic [15:0] temp_dc;   // signed 0.1 degC
      logic [15:0] cell_max;
      logic [15:0] cell_min;
   } meas_t;

   typedef struct packed {
      logic cell_overvoltage_flag;
      logic cell_undervoltage_flag;
      logic overtemp;
      logic perm_fail;
      logic chg_fet;
      logic dsg_fet;
   } stat_t;

endpackage : prot_pkg

/* battery_protection_monitor.sv */
// Purpose: Protection supervisor: thresholds vs measurements, FET control
// Assumes: Measurement frames arrive with a one-cycle strobe on pclk
// Notes:   Front-end alert is asynchronous; it is synchronised here
//
// Function
// - Pack at charge voltage plus margin sets overvoltage, charge FET off.
// - Charge FET back on under small discharge current during overvoltage.
// - Discharge FET back on under small charge current after undervoltage.
// - Any cell at high limit sets overvoltage; clears when all below reset and pack below charge voltage.
// - Any cell at low limit sets undervoltage; clears when all above reset.
// - Overload average current sets undervoltage, discharge FET off.
// - All flag clearing is decided here, not by the front-end.
// - Optional two-measurement validation of overvoltage, undervoltage and safety overvoltage decisions.
// - Front-end alert; this block decides when switches return.
// - Cell limits and reset points held as millivolt values.
// - Discharge overcurrent held for programmed time opens discharge FET.
// - Charge overcurrent held for programmed time opens charge FET.
// - Safety overvoltage for validated period enters permanent failure.
// - Safety hot limits are unsigned tenths of a degree.
// - Safety hot beyond programmed time enters permanent failure.
// - Hot charge or discharge opens both FETs, sets overtemp bit.
// - Temperature disable bit suppresses all but safety hot checks.
// - Cold charge suspend opens charge FET; signed limit, capped.
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
module battery_protection_monitor (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [11:0]   paddr,
   input  wire logic [31:0]   pwdata,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire logic          meas_valid,
   input  wire prot_pkg::meas_t meas,
   input  wire logic          frontend_alert,
   output logic               chg_fet_on,
   output logic               dsg_fet_on,
   output logic               safe_n,
   output prot_pkg::stat_t    status
);
   import prot_pkg::*;

   // Configuration registers
   logic [5:0]  ctrl_q, ctrl_d;
   logic [15:0] chg_v_q, ov_margin_q, cell_high_limit_q, cell_hi_rs_q;
   logic [15:0] cell_low_limit_q, cell_lo_rs_q, ovld_q, fclr_q;
   logic [15:0] doc_i_q, coc_i_q, safe_v_q;
   logic [15:0] safety_hot_charge_limit_q, safety_hot_discharge_limit_q;
   logic [15:0] hot_c_q, hot_c_rs_q, hot_d_q, hot_d_rs_q;
   logic [15:0] cold_charge_suspend_limit_q;
   logic [7:0]  doc_t_q, coc_t_q, sot_t_q;
   logic [15:0] wr16;
   logic        wr;

   assign wr   = psel & penable & pwrite;
   assign wr16 = pwdata[15:0];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= CTRL_RST;
         chg_v_q <= Z16; ov_margin_q <= Z16;
         cell_high_limit_q <= U16_MAX; cell_hi_rs_q <= Z16;
         cell_low_limit_q <= Z16; cell_lo_rs_q <= Z16;
         ovld_q <= S16_MAX; fclr_q <= Z16;
         doc_i_q <= S16_MAX; coc_i_q <= S16_MAX;
         safe_v_q <= U16_MAX;
         safety_hot_charge_limit_q <= U16_MAX;
         safety_hot_discharge_limit_q <= U16_MAX;
         hot_c_q <= S16_MAX; hot_c_rs_q <= Z16;
         hot_d_q <= S16_MAX; hot_d_rs_q <= Z16;
         cold_charge_suspend_limit_q <= S16_MIN;
         doc_t_q <= Z8; coc_t_q <= Z8; sot_t_q <= Z8;
      end else begin
         ctrl_q <= ctrl_d;
         if (wr) begin
            unique case (paddr)
               A_CHG_V:      chg_v_q <= wr16;
               A_OV_MARGIN:  ov_margin_q <= wr16;
               A_CELL_HI:    cell_high_limit_q <= wr16;
               A_CELL_HI_RS: cell_hi_rs_q <= wr16;
               A_CELL_LO:    cell_low_limit_q <= wr16;
               A_CELL_LO_RS: cell_lo_rs_q <= wr16;
               A_OVLD_I:     ovld_q <= wr16;
               A_FCLR_I:     fclr_q <= wr16;
               A_DOC_I:      doc_i_q <= wr16;
               A_DOC_T:      doc_t_q <= pwdata[7:0];
               A_COC_I:      coc_i_q <= wr16;
               A_COC_T:      coc_t_q <= pwdata[7:0];
               A_SAFE_V:     safe_v_q <= wr16;
               A_SOT_C:      safety_hot_charge_limit_q <= wr16;
               A_SOT_D:      safety_hot_discharge_limit_q <= wr16;
               A_SOT_T:      sot_t_q <= pwdata[7:0];
               A_HOT_C:      hot_c_q <= wr16;
               A_HOT_C_RS:   hot_c_rs_q <= wr16;
               A_HOT_D:      hot_d_q <= wr16;
               A_HOT_D_RS:   hot_d_rs_q <= wr16;
               A_COLD_C:     cold_charge_suspend_limit_q <=
                  ($signed(wr16) > $signed(COLD_MAX)) ? COLD_MAX : wr16;
               default: ;
            endcase
         end
      end
   end

   // Control: clear strobe bit self-clears
   always_comb begin
      ctrl_d = ctrl_q;
      ctrl_d[C_PF_CLEAR] = 1'b0;
      if (wr && paddr == A_CTRL)
         ctrl_d = pwdata[5:0];
   end

   // Alert synchroniser
   logic alert_s1_q, alert_s2_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alert_s1_q <= 1'b0;
         alert_s2_q <= 1'b0;
      end else begin
         alert_s1_q <= frontend_alert;
         alert_s2_q <= alert_s1_q;
      end
   end

   // Comparisons on the current frame
   logic signed [15:0] cur, tmp;
   logic [16:0] ov_lvl;
   logic c_ov, c_ov_clr, c_cho, c_chu, c_cho_clr, c_chu_clr, c_olv, c_olv_clr;
   logic c_doc, c_coc, c_sov, c_safety_hot_charge_limit, c_safety_hot_discharge_limit, c_hot_c, c_hot_d, c_cold;
   logic c_hot_c_clr, c_hot_d_clr, dsg_small, chg_small, charging;
   always_comb begin
      cur = $signed(meas.avg_ma);
      tmp = $signed(meas.temp_dc);
      charging = cur > $signed(Z16);
      ov_lvl = {1'b0, chg_v_q} + {1'b0, ov_margin_q};
      c_ov = {1'b0, meas.pack_mv} >= ov_lvl;
      c_ov_clr = meas.pack_mv < chg_v_q;
      c_cho = meas.cell_max >= cell_high_limit_q;
      c_cho_clr = meas.cell_max < cell_hi_rs_q;
      c_chu = meas.cell_min <= cell_low_limit_q;
      c_chu_clr = meas.cell_min > cell_lo_rs_q;
      c_olv = cur < -$signed(ovld_q);
      c_olv_clr = cur < -$signed(fclr_q);
      c_doc = cur < -$signed(doc_i_q);
      c_coc = cur > $signed(coc_i_q);
      c_sov = meas.pack_mv > safe_v_q;
      c_safety_hot_charge_limit = charging && !tmp[15] &&
               meas.temp_dc > safety_hot_charge_limit_q;
      c_safety_hot_discharge_limit = !charging && !tmp[15] &&
               meas.temp_dc > safety_hot_discharge_limit_q;
      c_hot_c = charging && tmp >= $signed(hot_c_q);
      c_hot_d = !charging && tmp >= $signed(hot_d_q);
      c_hot_c_clr = tmp < $signed(hot_c_rs_q);
      c_hot_d_clr = tmp < $signed(hot_d_rs_q);
      c_cold = charging &&
               tmp <= $signed(cold_charge_suspend_limit_q);
      dsg_small = cur < $signed(Z16) && -cur <= $signed(DSG_ON_MA);
      chg_small = charging && cur <= $signed(CHG_ON_MA);
   end

   // Protection state
   logic ovp_q, ovp_d, uvp_q, uvp_d, olv_q, olv_d, hot_q, hot_d;
   logic pend_ov_q, pend_ov_d, pend_uv_q, pend_uv_d;
   logic doc_trip_q, doc_trip_d, coc_trip_q, coc_trip_d;
   logic sov_pend_q, sov_pend_d, pf_q, pf_d, afe_q, afe_d;
   logic [7:0] doc_cnt_q, doc_cnt_d, coc_cnt_q, coc_cnt_d;
   logic [7:0] sot_cnt_q, sot_cnt_d;
   logic chg_q, chg_d, dsg_q, dsg_d;
   logic val, ov_set, uv_set, tdis;

   always_comb begin
      val = ctrl_q[C_VALIDATE];
      tdis = ctrl_q[C_TDIS];
      ovp_d = ovp_q; uvp_d = uvp_q; olv_d = olv_q; hot_d = hot_q;
      pend_ov_d = pend_ov_q; pend_uv_d = pend_uv_q;
      doc_trip_d = doc_trip_q; coc_trip_d = coc_trip_q;
      doc_cnt_d = doc_cnt_q; coc_cnt_d = coc_cnt_q; sot_cnt_d = sot_cnt_q;
      sov_pend_d = sov_pend_q; pf_d = pf_q; afe_d = afe_q;
      ov_set = 1'b0;
      uv_set = 1'b0;
      if (alert_s2_q)
         afe_d = 1'b1;
      // Clear first so a trip in the same cycle wins
      if (ctrl_q[C_PF_CLEAR])
         pf_d = 1'b0;
      if (meas_valid) begin
         // Two-measurement confirmation when enabled
         ov_set = (c_ov || c_cho) && (!val || pend_ov_q);
         uv_set = c_chu && (!val || pend_uv_q);
         pend_ov_d = c_ov || c_cho;
         pend_uv_d = c_chu;
         if (ov_set)
            ovp_d = 1'b1;
         else if (ovp_q && c_ov_clr && c_cho_clr)
            ovp_d = 1'b0;
         if (uv_set)
            uvp_d = 1'b1;
         else if (uvp_q && c_chu_clr)
            uvp_d = 1'b0;
         if (c_olv)
            olv_d = 1'b1;
         else if (olv_q && c_olv_clr)
            olv_d = 1'b0;
         // Overcurrent persistence in frames
         doc_cnt_d = c_doc ? ((doc_cnt_q == CNT_MAX) ? doc_cnt_q
                              : doc_cnt_q + 8'h01) : Z8;
         coc_cnt_d = c_coc ? ((coc_cnt_q == CNT_MAX) ? coc_cnt_q
                              : coc_cnt_q + 8'h01) : Z8;
         if (c_doc && doc_cnt_q >= doc_t_q)
            doc_trip_d = 1'b1;
         else if (doc_trip_q && chg_small)
            doc_trip_d = 1'b0;
         if (c_coc && coc_cnt_q >= coc_t_q)
            coc_trip_d = 1'b1;
         else if (coc_trip_q && dsg_small)
            coc_trip_d = 1'b0;
         if (!tdis && (c_hot_c || c_hot_d))
            hot_d = 1'b1;
         else if (tdis || (c_hot_c_clr && c_hot_d_clr))
            hot_d = 1'b0;
         sov_pend_d = c_sov;
         if (c_sov && (!val || sov_pend_q) && ctrl_q[C_PF_SOV])
            pf_d = 1'b1;
         sot_cnt_d = (c_safety_hot_charge_limit || c_safety_hot_discharge_limit) ? ((sot_cnt_q == CNT_MAX)
                     ? sot_cnt_q : sot_cnt_q + 8'h01) : Z8;
         if (sot_cnt_q >= sot_t_q &&
             ((c_safety_hot_charge_limit && ctrl_q[C_PF_SAFETY_HOT_CHARGE_LIMIT]) ||
              (c_safety_hot_discharge_limit && ctrl_q[C_PF_SAFETY_HOT_DISCHARGE_LIMIT])))
            pf_d = 1'b1;
         if (afe_q && !alert_s2_q && (chg_small || dsg_small))
            afe_d = 1'b0;
      end
   end

   // FET decisions
   always_comb begin
      chg_d = 1'b1;
      dsg_d = 1'b1;
      if (ovp_q && !dsg_small)
         chg_d = 1'b0;
      if ((uvp_q || olv_q) && !chg_small)
         dsg_d = 1'b0;
      if (coc_trip_q)
         chg_d = 1'b0;
      if (doc_trip_q)
         dsg_d = 1'b0;
      if (!tdis && c_cold)
         chg_d = 1'b0;
      if (hot_q) begin
         chg_d = 1'b0;
         dsg_d = 1'b0;
      end
      // Front-end holds its own switch state while alerting
      if (afe_q) begin
         chg_d = chg_d & chg_q;
         dsg_d = dsg_d & dsg_q;
      end
      if (pf_q) begin
         chg_d = 1'b0;
         dsg_d = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovp_q <= 1'b0; uvp_q <= 1'b0; olv_q <= 1'b0; hot_q <= 1'b0;
         pend_ov_q <= 1'b0; pend_uv_q <= 1'b0;
         doc_trip_q <= 1'b0; coc_trip_q <= 1'b0;
         doc_cnt_q <= Z8; coc_cnt_q <= Z8; sot_cnt_q <= Z8;
         sov_pend_q <= 1'b0; pf_q <= 1'b0; afe_q <= 1'b0;
         chg_q <= 1'b0; dsg_q <= 1'b0;
      end else begin
         ovp_q <= ovp_d; uvp_q <= uvp_d; olv_q <= olv_d; hot_q <= hot_d;
         pend_ov_q <= pend_ov_d; pend_uv_q <= pend_uv_d;
         doc_trip_q <= doc_trip_d; coc_trip_q <= coc_trip_d;
         doc_cnt_q <= doc_cnt_d; coc_cnt_q <= coc_cnt_d;
         sot_cnt_q <= sot_cnt_d;
         sov_pend_q <= sov_pend_d; pf_q <= pf_d; afe_q <= afe_d;
         chg_q <= chg_d; dsg_q <= dsg_d;
      end
   end

   // Measurement capture for readback
   meas_t meas_q, meas_d;
   always_comb meas_d = meas_valid ? meas : meas_q;

   // Outputs and APB read path
   logic [31:0] rd_d;
   stat_t       st_d;
   always_comb begin
      st_d = '{cell_overvoltage_flag: ovp_q,
               cell_undervoltage_flag: uvp_q || olv_q,
               overtemp: hot_q, perm_fail: pf_q,
               chg_fet: chg_q, dsg_fet: dsg_q};
      rd_d = 32'h0000_0000;
      unique case (paddr)
         A_CTRL:       rd_d[5:0] = ctrl_q;
         A_CHG_V:      rd_d[15:0] = chg_v_q;
         A_OV_MARGIN:  rd_d[15:0] = ov_margin_q;
         A_CELL_HI:    rd_d[15:0] = cell_high_limit_q;
         A_CELL_HI_RS: rd_d[15:0] = cell_hi_rs_q;
         A_CELL_LO:    rd_d[15:0] = cell_low_limit_q;
         A_CELL_LO_RS: rd_d[15:0] = cell_lo_rs_q;
         A_OVLD_I:     rd_d[15:0] = ovld_q;
         A_FCLR_I:     rd_d[15:0] = fclr_q;
         A_DOC_I:      rd_d[15:0] = doc_i_q;
         A_DOC_T:      rd_d[7:0] = doc_t_q;
         A_COC_I:      rd_d[15:0] = coc_i_q;
         A_COC_T:      rd_d[7:0] = coc_t_q;
         A_SAFE_V:     rd_d[15:0] = safe_v_q;
         A_SOT_C:      rd_d[15:0] = safety_hot_charge_limit_q;
         A_SOT_D:      rd_d[15:0] = safety_hot_discharge_limit_q;
         A_SOT_T:      rd_d[7:0] = sot_t_q;
         A_HOT_C:      rd_d[15:0] = hot_c_q;
         A_HOT_C_RS:   rd_d[15:0] = hot_c_rs_q;
         A_HOT_D:      rd_d[15:0] = hot_d_q;
         A_HOT_D_RS:   rd_d[15:0] = hot_d_rs_q;
         A_COLD_C:     rd_d[15:0] = cold_charge_suspend_limit_q;
         A_STATUS:     rd_d[6:0] = {afe_q, st_d};
         A_MEAS_V:     rd_d[15:0] = meas_q.pack_mv;
         A_MEAS_I:     rd_d[15:0] = meas_q.avg_ma;
         A_MEAS_T:     rd_d[15:0] = meas_q.temp_dc;
         A_CELL_MAX:   rd_d[15:0] = meas_q.cell_max;
         A_CELL_MIN:   rd_d[15:0] = meas_q.cell_min;
         default:      rd_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         chg_fet_on <= 1'b0;
         dsg_fet_on <= 1'b0;
         safe_n <= 1'b1;
         status <= '0;
         meas_q <= '0;
      end else begin
         // No wait state: ready in the cycle after setup
         pready <= psel && !penable;
         pslverr <= 1'b0;
         prdata <= rd_d;
         chg_fet_on <= chg_d;
         dsg_fet_on <= dsg_d;
         safe_n <= !pf_d;
         status <= st_d;
         meas_q <= meas_d;
      end
   end

endmodule : battery_protection_monitor

/* prot_asserts.sv */
// Purpose: Port-level checks for the protection monitor
// Assumes: Single pclk domain, presetn async active low
// Notes:   Bound to every instance of the monitor
`timescale 1ns/1ps
module prot_asserts (
   input logic              pclk,
   input logic              presetn,
   input logic              psel,
   input logic              penable,
   input logic              pwrite,
   input logic [11:0]       paddr,
   input logic [31:0]       pwdata,
   input logic [31:0]       prdata,
   input logic              pready,
   input logic              pslverr,
   input logic              meas_valid,
   input prot_pkg::meas_t   meas,
   input logic              frontend_alert,
   input logic              chg_fet_on,
   input logic              dsg_fet_on,
   input logic              safe_n,
   input prot_pkg::stat_t   status
);
   import prot_pkg::*;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic wr_acc;
   assign wr_acc = psel && penable && pwrite;
   a_ready_next: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_no_error: assert property (psel && penable |-> !pslverr)
      else $error("slave error raised");
   a_cov_cause: assert property ($changed(status.cell_overvoltage_flag)
      |-> $past(meas_valid) || $past(meas_valid, 2))
      else $error("overvoltage flag moved without frame");
   a_cuv_cause: assert property ($changed(status.cell_undervoltage_flag)
      |-> $past(meas_valid) || $past(meas_valid, 2))
      else $error("undervoltage flag moved without frame");
   a_hot_both_off: assert property (status.overtemp && $past(status.overtemp)
      |-> !chg_fet_on && !dsg_fet_on)
      else $error("FET on while hot");
   a_chg_small: assert property ($rose(chg_fet_on) ##1
      status.cell_overvoltage_flag |-> $signed(meas.avg_ma) >= -150
      && $signed(meas.avg_ma) <= 0)
      else $error("charge FET on during overvoltage");
   a_dsg_small: assert property ($rose(dsg_fet_on) ##1
      status.cell_undervoltage_flag |-> $signed(meas.avg_ma) >= 0
      && $signed(meas.avg_ma) <= 50)
      else $error("discharge FET on during undervoltage");
   a_safe_cause: assert property ($fell(safe_n)
      |-> $past(meas_valid) || $past(meas_valid, 2))
      else $error("safe output fell without frame");
   a_safe_clear: assert property ($rose(safe_n)
      |-> $past(wr_acc) || $past(wr_acc, 2))
      else $error("safe output released without write");
   a_pf_flag: assert property (!safe_n |-> ##[0:2] status.perm_fail)
      else $error("failure flag missing");
   c_hot: cover property ($rose(status.overtemp));
   c_pf: cover property ($fell(safe_n));
   c_ov_on: cover property (status.cell_overvoltage_flag && chg_fet_on);
endmodule : prot_asserts
bind battery_protection_monitor prot_asserts u_chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .meas_valid(meas_valid), .meas(meas),
   .frontend_alert(frontend_alert), .chg_fet_on(chg_fet_on),
   .dsg_fet_on(dsg_fet_on), .safe_n(safe_n), .status(status));

/* afe_model.sv */
// Purpose: Front-end stand-in: measurement frames and protection alert
// Assumes: Outputs change just after a rising pclk edge
// Notes:   Frame values stay put until the next frame
`timescale 1ns/1ps
module afe_model (
   input  logic             pclk,
   output logic             meas_valid,
   output prot_pkg::meas_t  meas,
   output logic             frontend_alert
);
   import prot_pkg::*;
   initial begin
      meas_valid = 1'b0;
      meas = '0;
      frontend_alert = 1'b0;
   end
   // One-cycle strobe per frame
   task send(input meas_t m);
      meas <= m;
      meas_valid <= 1'b1;
      @(posedge pclk);
      meas_valid <= 1'b0;
   endtask : send
   // Level alert after own trip; local switches already set
   task alert(input logic v);
      frontend_alert <= v;
   endtask : alert
endmodule : afe_model

/* test_battery_protection_monitor.sv */
// Purpose: Self-checking bench for the protection monitor
// Assumes: Frames spaced seven cycles, APB with one idle cycle
// Notes:   Expected results queued by drivers, popped by monitor
`timescale 1ns/1ps
module test_battery_protection_monitor;
   import prot_pkg::*;
   localparam logic [15:0] V0 = 16'h2AF8, I0 = 16'hFE0C, T0 = 16'h00FA;
   localparam logic [15:0] H0 = 16'h0E74, L0 = 16'h0E10;
   logic        pclk = 1'b0, presetn = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, seed = 32'h00015093;
   logic        pready, pslverr, meas_valid, frontend_alert;
   logic        chg_fet_on, dsg_fet_on, safe_n;
   meas_t       meas;
   stat_t       status;
   int          errors = 0, tests_run = 0;
   logic [31:0] rq [$];
   logic [11:0] fq [$];
   logic [11:0] fm;
   logic [8:0]  fv, ev, mm;
   logic [3:0]  sr = 4'h0;
   logic [15:0] tv [21] = '{16'h2EE0, 16'h012C, 16'h10CC, 16'h1004,
      16'h0AF0, 16'h0BB8, 16'h1388, 16'h0064, 16'h0BB8, 16'h0002,
      16'h0BB8, 16'h0002, 16'h32C8, 16'h0258, 16'h028A, 16'h0001,
      16'h01C2, 16'h0190, 16'h0226, 16'h01F4, 16'h0032};
   always #20 pclk = ~pclk;
   battery_protection_monitor DUT (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .meas_valid(meas_valid), .meas(meas),
      .frontend_alert(frontend_alert), .chg_fet_on(chg_fet_on),
      .dsg_fet_on(dsg_fet_on), .safe_n(safe_n), .status(status));
   afe_model u_afe (.pclk(pclk), .meas_valid(meas_valid), .meas(meas),
      .frontend_alert(frontend_alert));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : tally_and_finish
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      if (!w) rq.push_back(d);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= w ? d : 32'h0;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         errors++;
         tally_and_finish();
      end
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task f(input logic [15:0] v, i, t, h, l, input logic [5:0] e,
          input logic [5:0] m = 6'h3F);
      fq.push_back({e, m});
      u_afe.send('{v, i, t, h, l});
      repeat (6) @(posedge pclk);
   endtask : f
   always @(negedge pclk) begin
      sr <= {sr[2:0], meas_valid};
      if (psel && penable && pready && !pwrite)
         check(prdata, rq.pop_front());
      if (sr[3]) begin
         fm = fq.pop_front();
         mm = {fm[5:0], fm[1:0], fm[2]};
         fv = {status, chg_fet_on, dsg_fet_on, !safe_n};
         ev = {fm[11:6], fm[7:6], fm[8]};
         check(32'(fv & mm), 32'(ev & mm));
      end
   end
   initial begin
      repeat (20000) @(posedge pclk);
      errors++;
      tally_and_finish();
   end
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(0, A_CTRL, 32'h1);
      apb(0, 12'hFF0, 32'h0);
      for (int k = 0; k < 21; k++) apb(1, 12'(4 * k + 4), {16'h0, tv[k]});
      apb(0, A_CELL_HI, 32'h10CC);
      f(V0, I0, T0, 16'h10CC, L0, 6'h03);
      f(V0, I0, T0, 16'h10CC, L0, 6'h21);
      apb(1, A_CTRL, 32'h0);
      f(V0, I0, T0, 16'h1068, L0, 6'h21);
      f(V0, I0, T0, 16'h0FA0, L0, 6'h03);
      f(16'h300C, I0, T0, H0, L0, 6'h21);
      f(16'h300C, 16'hFF9C, T0, H0, L0, 6'h23);
      f(16'h2E7C, 16'hFF9C, T0, H0, L0, 6'h03);
      f(V0, I0, T0, H0, 16'h0AF0, 6'h12);
      f(V0, 16'h001E, T0, H0, 16'h0B54, 6'h13);
      f(V0, I0, T0, H0, 16'h0C1C, 6'h03);
      f(V0, 16'hEC77, T0, H0, L0, 6'h12);
      f(V0, 16'hFF38, T0, H0, L0, 6'h03);
      for (int k = 0; k < 2; k++) begin
         f(V0, k ? 16'h0DAC : 16'hF254, T0, H0, L0, 6'h03);
         f(V0, k ? 16'h0DAC : 16'hF254, T0, H0, L0, 6'h00, 6'h00);
         f(V0, k ? 16'h0DAC : 16'hF254, T0, H0, L0, k ? 6'h01 : 6'h02);
         f(V0, k ? 16'hFF9C : 16'h001E, T0, H0, L0, 6'h03);
      end
      f(V0, 16'h01F4, 16'h01F4, H0, L0, 6'h08);
      f(V0, 16'h01F4, T0, H0, L0, 6'h03);
      f(V0, I0, 16'h0230, H0, L0, 6'h08);
      f(V0, I0, T0, H0, L0, 6'h03);
      apb(1, A_CTRL, 32'h2);
      f(V0, 16'h01F4, 16'h01F4, H0, L0, 6'h03);
      f(V0, 16'h01F4, 16'hFFF6, H0, L0, 6'h03);
      apb(1, A_CTRL, 32'h0);
      f(V0, 16'h01F4, 16'hFFF6, H0, L0, 6'h01);
      f(V0, I0, T0, H0, L0, 6'h03);
      f(16'h300C, I0, T0, H0, L0, 6'h21);
      u_afe.alert(1'b1);
      repeat (4) @(posedge pclk);
      f(V0, 16'h0000, T0, H0, L0, 6'h01);
      u_afe.alert(1'b0);
      repeat (4) @(posedge pclk);
      f(V0, 16'h000A, T0, H0, L0, 6'h03);
      apb(1, A_CTRL, 32'h4);
      f(16'h332C, I0, T0, H0, L0, 6'h24, 6'h3C);
      apb(1, A_CTRL, 32'h20);
      f(V0, I0, T0, H0, L0, 6'h00, 6'h3C);
      apb(1, A_CTRL, 32'h8);
      repeat (2) f(V0, 16'h01F4, 16'h028A, H0, L0, 6'h00, 6'h00);
      f(V0, 16'h01F4, 16'h028A, H0, L0, 6'h0C, 6'h0C);
      apb(1, A_CTRL, 32'h20);
      apb(0, A_MEAS_V, {16'h0, V0});
      for (int k = 0; k < 4; k++) begin
         seed = lfsr(seed);
         f(16'h2328 + 16'(seed[10:0]), 16'(seed[26:16]) - 16'h0400, T0,
           16'h0C80 + 16'(seed[9:0]), 16'h0C80 + 16'(seed[9:0]),
           6'h03);
      end
      tally_and_finish();
   end
endmodule : test_battery_protection_monitor
